// ---- common/rail_enable_pkg.sv ----
// Constants shared by the rail-enable register bank and its helpers.
// Assumes an I2C front end that presents decoded subaddress strobes.
package rail_enable_pkg;

    // ------------------------------------------------------------
    // Subaddresses
    // ------------------------------------------------------------
    localparam logic [7:0] UNLOCK_KEY_OFS = 8'h10;
    localparam logic [7:0] CONVERTER_ENABLE_OFS = 8'h11;
    localparam logic [7:0] AUXILIARY_ENABLE_OFS = 8'h12;

    // ------------------------------------------------------------
    // Widths, resets and read-back values
    // ------------------------------------------------------------
    localparam int CONV_W = 6;
    localparam int AUX_W = 7;
    localparam logic [5:0] CONV_RESET = 6'h00;
    localparam logic [6:0] AUX_RESET = 7'h00;
    localparam logic [7:0] KEY_RESET = 8'h00;
    localparam logic [7:0] KEY_READ_VALUE = 8'h00;
    localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CONV_FIVE_BIT = 4;
    localparam int CONV_SIX_BIT = 5;
    localparam int SEQ_CONV_W = 5;
    localparam int SEQ_AUX_W = 2;
    localparam int GP_ONE_BIT = 4;
    localparam int GP_TWO_BIT = 5;
    localparam int GP_THREE_BIT = 6;

    // Arbitrary neutral value; the key a write must carry is addr xor this
    localparam logic [7:0] UNLOCK_KEY_MASK = 8'h7D;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Bits under mask take new value, others keep old
    function automatic logic [7:0] merge_bits(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic [7:0] mask);
        merge_bits = (old_v & ~mask) | (new_v & mask);
    endfunction : merge_bits

endpackage : rail_enable_pkg

// ---- hdl/unlock_gate.sv ----
// Tracks the unlock sequence: a key write arms, the very next write is checked.
// Assumes write strobes are one-cycle pulses synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module unlock_gate
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic wr_stb,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    output logic grant
);
    import rail_enable_pkg::*;

    typedef struct packed {
        logic armed;
        logic [7:0] key;
    } gate_state_t;

    gate_state_t s_q;
    gate_state_t s_d;
    logic is_prot;

    assign is_prot = (wr_addr == CONVERTER_ENABLE_OFS) || (wr_addr == AUXILIARY_ENABLE_OFS);
    // Key must be armed and equal the target subaddress xor UNLOCK_KEY_MASK
    assign grant = wr_stb && is_prot && s_q.armed
                   && (s_q.key == (wr_addr ^ UNLOCK_KEY_MASK));

    always_comb
    begin
        s_d = s_q;
        if (wr_stb)
        begin
            // Any write consumes the arming, so a stale key never unlocks
            s_d.armed = (wr_addr == UNLOCK_KEY_OFS);
            if (wr_addr == UNLOCK_KEY_OFS)
            begin
                s_d.key = wr_data;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_q <= '{armed: 1'b0, key: KEY_RESET};
        end
        else
        begin
            s_q <= s_d;
        end
    end

endmodule : unlock_gate
`default_nettype wire

// ---- hdl/gp_pin_mux.sv ----
// Drives the three general-purpose pins and the warm-reset request.
// Assumes pin inputs are already synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module gp_pin_mux
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic gp_out_one_level,
    input wire logic gp_out_two_level,
    input wire logic gp_out_three_level,
    input wire logic warm_reset_pin_select,
    input wire logic gpio_route_select,
    input wire logic gp_pin_one_in,
    input wire logic gp_pin_three_in,
    output logic gp_pin_one_oe_n,
    output logic gp_pin_two_oe_n,
    output logic gp_pin_three_oe_n,
    output logic warm_reset_conv12
);
    typedef struct packed {
        logic one_oe_n;
        logic two_oe_n;
        logic three_oe_n;
        logic warm_rst;
    } pin_state_t;

    pin_state_t s_q;
    pin_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        // Open drain: enable low means pulled low, high means released
        s_d.one_oe_n = gpio_route_select | gp_out_one_level;
        s_d.two_oe_n = gpio_route_select ? gp_pin_one_in : gp_out_two_level;
        s_d.three_oe_n = warm_reset_pin_select | gp_out_three_level;
        s_d.warm_rst = warm_reset_pin_select & ~gp_pin_three_in;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_q <= '{one_oe_n: 1'b0, two_oe_n: 1'b0, three_oe_n: 1'b0, warm_rst: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign gp_pin_one_oe_n = s_q.one_oe_n;
    assign gp_pin_two_oe_n = s_q.two_oe_n;
    assign gp_pin_three_oe_n = s_q.three_oe_n;
    assign warm_reset_conv12 = s_q.warm_rst;

    default clocking pm_cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // Pins still show their reset state at the first edge after release
    pin_three_hold_a: assert property ($past(warm_reset_pin_select) && !$past(sys_rst)
                                      |-> gp_pin_three_oe_n)
        else $error("pin three driven while in warm-reset mode");
    pin_two_route_a: assert property ($past(gpio_route_select)
                                      |-> gp_pin_two_oe_n == $past(gp_pin_one_in))
        else $error("pin two does not follow pin one input");

endmodule : gp_pin_mux
`default_nettype wire

// ---- hdl/rail_enable_register_bank.sv ----
// Unlock-key register and the two rail-enable registers of the power manager.
// Assumes an I2C slave front end giving one-cycle write and read strobes with
// a subaddress, a power sequencer with its own update strobe, and seal and
// select levels from the configuration logic.
//
// How it works
// - Key register always reads back zero
// - Key write must precede protected register writes
// - Key writes forwarded to freshness seal logic
// - Key writes forwarded to default programming logic
// - Converter register resets zero, protected, bits 7:6 zero
// - Auxiliary register resets zero, protected, bit 7 zero
// - Bits 0 to 5 switch six converters
// - Sixth converter clear ignored while seal set
// - Fifth converter host-write clear ignored while seal set
// - Sequencer updates converters one to five
// - Aux bits 1,0: switch one, linear regulator
// - Aux bits 3,2: switches three and two
// - Aux bit 6 pulls third pin low
// - Warm-reset select disables aux bit 6
// - Aux bit 5 pulls second pin low
// - Aux bit 4 pulls first pin low
// - Routing select disables aux bits 4,5
// - Warm-reset select makes pin three an input
// - Routing select: pin one drives pin two
`timescale 1ns/1ns
`default_nettype none
module rail_enable_register_bank
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Register port from the I2C front end
    input wire logic reg_wr_stb,
    input wire logic reg_rd_stb,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Power sequencer
    input wire logic seq_upd_stb,
    input wire logic [rail_enable_pkg::SEQ_CONV_W-1:0] seq_conv_bits,
    input wire logic [rail_enable_pkg::SEQ_AUX_W-1:0] seq_aux_bits,
    // Configuration levels owned elsewhere
    input wire logic factory_seal_flag,
    input wire logic warm_reset_pin_select,
    input wire logic gpio_route_select,
    // Key forwarding to seal and default-programming logic
    output logic key_wr_pulse,
    output logic [7:0] unlock_key_field,
    // Rail enables
    output logic conv_one_on,
    output logic conv_two_on,
    output logic conv_three_on,
    output logic conv_four_on,
    output logic conv_five_on,
    output logic conv_six_on,
    output logic linear_reg_on,
    output logic switch_one_on,
    output logic switch_two_on,
    output logic switch_three_on,
    // General-purpose pins, open drain
    input wire logic gp_pin_one_in,
    output logic gp_pin_one_out,
    output logic gp_pin_one_oe_n,
    output logic gp_pin_two_out,
    output logic gp_pin_two_oe_n,
    input wire logic gp_pin_three_in,
    output logic gp_pin_three_out,
    output logic gp_pin_three_oe_n,
    output logic warm_reset_conv12
);
    import rail_enable_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [CONV_W-1:0] conv;
        logic [AUX_W-1:0] aux;
        logic [7:0] rdata;
        logic rvalid;
        logic key_wr;
        logic [7:0] key;
        logic zero_out;
    } bank_state_t;

    bank_state_t s_q;
    bank_state_t s_d;
    logic grant;
    logic [7:0] conv_wr;
    logic [7:0] conv_ext;
    logic [7:0] aux_ext;
    logic [7:0] conv_seq;
    logic [7:0] aux_seq;
    logic [7:0] conv_keep;
    // Merge results, sliced back to register width after the call
    logic [7:0] conv_mrg;
    logic [7:0] aux_mrg;

    // ------------------------------------------------------------
    // Unlock check
    // ------------------------------------------------------------
    unlock_gate u_gate
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .wr_stb(reg_wr_stb),
        .wr_addr(reg_addr),
        .wr_data(reg_wdata),
        .grant(grant)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    assign conv_ext = {2'b00, s_q.conv};
    assign aux_ext = {1'b0, s_q.aux};
    // Seal set: backup converters may be set but not cleared
    assign conv_keep = {2'b00, factory_seal_flag, factory_seal_flag, 4'h0} & conv_ext;
    assign conv_wr = ({2'b00, reg_wdata[CONV_W-1:0]} | conv_keep);
    assign conv_seq = {3'b000, seq_conv_bits};
    assign aux_seq = {6'b000000, seq_aux_bits};

    always_comb
    begin
        s_d = s_q;
        conv_mrg = 8'h00;
        aux_mrg = 8'h00;
        s_d.rvalid = reg_rd_stb;
        s_d.key_wr = 1'b0;
        if (reg_rd_stb)
        begin
            case (reg_addr)
                UNLOCK_KEY_OFS: s_d.rdata = KEY_READ_VALUE;
                CONVERTER_ENABLE_OFS: s_d.rdata = conv_ext;
                AUXILIARY_ENABLE_OFS: s_d.rdata = aux_ext;
                default: s_d.rdata = UNMAPPED_READ_VALUE;
            endcase
        end
        if (reg_wr_stb && (reg_addr == UNLOCK_KEY_OFS))
        begin
            s_d.key_wr = 1'b1;
            s_d.key = reg_wdata;
        end
        // Host write only when unlocked; otherwise contents stay
        if (grant && (reg_addr == CONVERTER_ENABLE_OFS))
        begin
            s_d.conv = conv_wr[CONV_W-1:0];
        end
        if (grant && (reg_addr == AUXILIARY_ENABLE_OFS))
        begin
            s_d.aux = reg_wdata[AUX_W-1:0];
        end
        // Sequencer wins over a host write in the same cycle
        if (seq_upd_stb)
        begin
            conv_mrg = merge_bits({2'b00, s_d.conv}, conv_seq, 8'h1F);
            aux_mrg = merge_bits({1'b0, s_d.aux}, aux_seq, 8'h03);
            s_d.conv = conv_mrg[CONV_W-1:0];
            s_d.aux = aux_mrg[AUX_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s_q <= '{conv: CONV_RESET, aux: AUX_RESET, rdata: UNMAPPED_READ_VALUE,
                     rvalid: 1'b0, key_wr: 1'b0, key: KEY_RESET,
                     zero_out: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = s_q.rdata;
    assign reg_rvalid = s_q.rvalid;
    assign key_wr_pulse = s_q.key_wr;
    assign unlock_key_field = s_q.key;
    assign conv_one_on = s_q.conv[0];
    assign conv_two_on = s_q.conv[1];
    assign conv_three_on = s_q.conv[2];
    assign conv_four_on = s_q.conv[3];
    assign conv_five_on = s_q.conv[CONV_FIVE_BIT];
    assign conv_six_on = s_q.conv[CONV_SIX_BIT];
    assign linear_reg_on = s_q.aux[0];
    assign switch_one_on = s_q.aux[1];
    assign switch_two_on = s_q.aux[2];
    assign switch_three_on = s_q.aux[3];
    // Open drain pins never drive high
    assign gp_pin_one_out = s_q.zero_out;
    assign gp_pin_two_out = s_q.zero_out;
    assign gp_pin_three_out = s_q.zero_out;

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    gp_pin_mux u_pins
    (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .gp_out_one_level(s_q.aux[GP_ONE_BIT]),
        .gp_out_two_level(s_q.aux[GP_TWO_BIT]),
        .gp_out_three_level(s_q.aux[GP_THREE_BIT]),
        .warm_reset_pin_select(warm_reset_pin_select),
        .gpio_route_select(gpio_route_select),
        .gp_pin_one_in(gp_pin_one_in),
        .gp_pin_three_in(gp_pin_three_in),
        .gp_pin_one_oe_n(gp_pin_one_oe_n),
        .gp_pin_two_oe_n(gp_pin_two_oe_n),
        .gp_pin_three_oe_n(gp_pin_three_oe_n),
        .warm_reset_conv12(warm_reset_conv12)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking bank_cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    key_read_zero_a: assert property (reg_rd_stb && reg_addr == UNLOCK_KEY_OFS
                                      |=> reg_rvalid && reg_rdata == 8'h00)
        else $error("key register read back nonzero");
    key_forward_a: assert property (reg_wr_stb && reg_addr == UNLOCK_KEY_OFS
                                    |=> key_wr_pulse && unlock_key_field == $past(reg_wdata))
        else $error("key write not forwarded");
    locked_write_a: assert property (reg_wr_stb && !grant && !seq_upd_stb
                                      |=> $stable(s_q.conv) && $stable(s_q.aux))
        else $error("locked write changed an enable register");
    conv_write_a: assert property (grant && reg_addr == CONVERTER_ENABLE_OFS && !seq_upd_stb
                                   && !factory_seal_flag
                                   |=> s_q.conv == $past(reg_wdata[5:0]))
        else $error("converter write not applied");
    six_seal_a: assert property (factory_seal_flag && conv_six_on && !seq_upd_stb
                                 |=> conv_six_on)
        else $error("sixth converter cleared while sealed");
    five_seal_a: assert property (factory_seal_flag && conv_five_on && !seq_upd_stb
                                  |=> conv_five_on)
        else $error("fifth converter cleared while sealed");
    seq_conv_a: assert property (seq_upd_stb
                                 |=> s_q.conv[4:0] == $past(seq_conv_bits))
        else $error("sequencer update of converters lost");
    seq_aux_a: assert property (seq_upd_stb
                                |=> {switch_one_on, linear_reg_on} == $past(seq_aux_bits))
        else $error("sequencer update of aux bits lost");
    reserved_zero_a: assert property (reg_rvalid && $past(reg_addr) != UNLOCK_KEY_OFS
                                      |-> reg_rdata[7] == 1'b0)
        else $error("reserved bit read as one");
    pin_one_low_a: assert property (!gpio_route_select && !s_q.aux[GP_ONE_BIT]
                                    ##1 !$past(gpio_route_select) |-> !gp_pin_one_oe_n)
        else $error("first pin not pulled low");

    unlock_write_c: cover property (grant ##1 conv_one_on);
    seq_power_up_c: cover property (seq_upd_stb ##1 conv_five_on);
    seal_block_c: cover property (factory_seal_flag && grant && !reg_wdata[5] && conv_six_on);
    warm_reset_c: cover property (warm_reset_conv12);

endmodule : rail_enable_register_bank
`default_nettype wire

// ---- dv/host_model.sv ----
// Host processor model: register write and read cycles on the port.
// Assumes strobes are taken on the rising edge of ref_clk.
`timescale 1ns/1ns
`default_nettype none
module host_model
(
    input wire logic ref_clk,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    output logic reg_wr_stb,
    output logic reg_rd_stb,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    import rail_enable_pkg::*;

    initial
    begin
        reg_wr_stb = 1'b0;
        reg_rd_stb = 1'b0;
        reg_addr = 8'hA5;
        reg_wdata = 8'h5A;
    end

    // Released lines flip so a stale address can never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_wr_stb = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge ref_clk);
        #1;
        reg_wr_stb = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge ref_clk);
        #1;
        reg_rd_stb = 1'b1;
        reg_addr = a;
        @(posedge ref_clk);
        #1;
        reg_rd_stb = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
        v = reg_rvalid;
    endtask : rd
endmodule : host_model
`default_nettype wire

// ---- dv/rail_enable_register_bank_tb.sv ----
// Self-checking bench for the rail-enable register bank.
// Assumes open-drain pins with pull-ups; host cycles come from host_model.
`timescale 1ns/1ns
`default_nettype none
module rail_enable_register_bank_tb;
    import rail_enable_pkg::*;
    logic ref_clk, sys_rst, reg_wr_stb, reg_rd_stb, reg_rvalid, seq_upd_stb;
    logic factory_seal_flag, warm_reset_pin_select, gpio_route_select, key_wr_pulse;
    logic conv_one_on, conv_two_on, conv_three_on, conv_four_on, conv_five_on;
    logic conv_six_on, linear_reg_on, switch_one_on, switch_two_on, switch_three_on;
    logic gp_pin_one_in, gp_pin_one_out, gp_pin_one_oe_n, gp_pin_two_out;
    logic gp_pin_two_oe_n, gp_pin_three_in, gp_pin_three_out, gp_pin_three_oe_n;
    logic warm_reset_conv12, ext_one, ext_three;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, unlock_key_field, m_conv, m_aux;
    logic [4:0] seq_conv_bits;
    logic [1:0] seq_aux_bits;
    logic [31:0] rnd;
    int n_mismatch, checks, m_key;

    // Pulled-up wires: low whenever the device enables its driver
    assign gp_pin_one_in = gp_pin_one_oe_n ? ext_one : 1'b0;
    assign gp_pin_three_in = gp_pin_three_oe_n ? ext_three : 1'b0;

    rail_enable_register_bank rail_enable_register_bank_i
    (
        .ref_clk, .sys_rst, .reg_wr_stb, .reg_rd_stb, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_rvalid, .seq_upd_stb, .seq_conv_bits, .seq_aux_bits,
        .factory_seal_flag, .warm_reset_pin_select, .gpio_route_select,
        .key_wr_pulse, .unlock_key_field, .conv_one_on, .conv_two_on,
        .conv_three_on, .conv_four_on, .conv_five_on, .conv_six_on,
        .linear_reg_on, .switch_one_on, .switch_two_on, .switch_three_on,
        .gp_pin_one_in, .gp_pin_one_out, .gp_pin_one_oe_n, .gp_pin_two_out,
        .gp_pin_two_oe_n, .gp_pin_three_in, .gp_pin_three_out,
        .gp_pin_three_oe_n, .warm_reset_conv12
    );

    host_model host_model_i
    (
        .ref_clk, .reg_rdata, .reg_rvalid, .reg_wr_stb, .reg_rd_stb, .reg_addr,
        .reg_wdata
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction : lfsr_next

    task automatic end_sim;
        if (n_mismatch == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Host write plus the model's view of the unlock sequence
    task automatic hwr(input logic [7:0] a, input logic [7:0] d);
        host_model_i.wr(a, d);
        if (a == UNLOCK_KEY_OFS)
        begin
            m_key = int'(d);
            chk(key_wr_pulse, 8'h01);
            chk(unlock_key_field, d);
        end
        else
        begin
            if (m_key == int'(a ^ UNLOCK_KEY_MASK) && a == CONVERTER_ENABLE_OFS)
                m_conv = (d & 8'h3F) | (factory_seal_flag ? (m_conv & 8'h30) : 8'h00);
            if (m_key == int'(a ^ UNLOCK_KEY_MASK) && a == AUXILIARY_ENABLE_OFS)
                m_aux = d & 8'h7F;
            m_key = -1;
        end
    endtask : hwr

    task automatic hunlock(input logic [7:0] a, input logic [7:0] d);
        hwr(UNLOCK_KEY_OFS, a ^ UNLOCK_KEY_MASK);
        hwr(a, d);
    endtask : hunlock

    task automatic seq_pulse(input logic [4:0] c, input logic [1:0] x);
        @(posedge ref_clk);
        #1;
        seq_upd_stb = 1'b1;
        seq_conv_bits = c;
        seq_aux_bits = x;
        @(posedge ref_clk);
        #1;
        seq_upd_stb = 1'b0;
        seq_conv_bits = ~c;
        seq_aux_bits = ~x;
        m_conv[4:0] = c;
        m_aux[1:0] = x;
    endtask : seq_pulse

    task automatic check_all;
        logic [7:0] d;
        logic v;
        logic [7:0] p1, p2, p3;
        host_model_i.rd(UNLOCK_KEY_OFS, d, v);
        chk(d, KEY_READ_VALUE);
        chk(v, 8'h01);
        host_model_i.rd(CONVERTER_ENABLE_OFS, d, v);
        chk(d, m_conv);
        host_model_i.rd(AUXILIARY_ENABLE_OFS, d, v);
        chk(d, m_aux);
        chk({conv_six_on, conv_five_on, conv_four_on, conv_three_on, conv_two_on,
             conv_one_on}, m_conv);
        chk({switch_three_on, switch_two_on, switch_one_on, linear_reg_on},
            m_aux & 8'h0F);
        p1 = gpio_route_select ? 8'h01 : 8'(m_aux[4]);
        p2 = gpio_route_select ? 8'(ext_one) : 8'(m_aux[5]);
        p3 = warm_reset_pin_select ? 8'h01 : 8'(m_aux[6]);
        chk(gp_pin_one_oe_n, p1);
        chk(gp_pin_two_oe_n, p2);
        chk(gp_pin_three_oe_n, p3);
        chk(warm_reset_conv12, 8'(warm_reset_pin_select & ~ext_three));
        chk({gp_pin_one_out, gp_pin_two_out, gp_pin_three_out}, 8'h00);
    endtask : check_all

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0] d;
        logic v;
        {seq_upd_stb, seq_conv_bits, seq_aux_bits, factory_seal_flag} = '0;
        {warm_reset_pin_select, gpio_route_select, ext_one, ext_three} = 4'h3;
        {m_conv, m_aux, n_mismatch, checks} = '0;
        m_key = -1;
        rnd = 32'h000023F8;
        sys_rst = 1'b1;
        repeat (8) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        check_all;
        hwr(CONVERTER_ENABLE_OFS, 8'hFF);
        hwr(UNLOCK_KEY_OFS, 8'h00);
        hwr(CONVERTER_ENABLE_OFS, 8'hFF);
        hwr(UNLOCK_KEY_OFS, 8'h6F);
        hwr(8'h20, 8'hFF);
        hwr(AUXILIARY_ENABLE_OFS, 8'hFF);
        host_model_i.rd(8'h20, d, v);
        chk(d, UNMAPPED_READ_VALUE);
        check_all;
        for (int i = 0; i < 12; i++)
        begin
            rnd = lfsr_next(rnd);
            @(posedge ref_clk);
            #1;
            {factory_seal_flag, warm_reset_pin_select, gpio_route_select} = rnd[2:0];
            {ext_one, ext_three} = rnd[4:3];
            hunlock(CONVERTER_ENABLE_OFS, rnd[15:8]);
            hunlock(AUXILIARY_ENABLE_OFS, rnd[23:16]);
            check_all;
            seq_pulse(rnd[28:24], rnd[30:29]);
            check_all;
        end
        factory_seal_flag = 1'b1;
        hunlock(CONVERTER_ENABLE_OFS, 8'hFF);
        hunlock(CONVERTER_ENABLE_OFS, 8'h00);
        check_all;
        @(posedge ref_clk);
        #1;
        sys_rst = 1'b1;
        @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        {m_conv, m_aux} = '0;
        m_key = -1;
        check_all;
        end_sim;
    end

    initial
    begin
        #100000;
        n_mismatch++;
        end_sim;
    end
endmodule : rail_enable_register_bank_tb
`default_nettype wire
